// ### core/idle_power_ctrl.sv
// Idle-mode power controller with peripheral disable and stop-in-idle control.
// Assumes the core pulses a power-save request and wake inputs are core_clk synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "idle_power_regs.svh"
module idle_power_ctrl (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire idle_power_pkg::reg_req_s req,
	output logic [15:0] rdata,
	// Core handshake
	input wire logic power_save_instruction,
	input wire logic irq_enabled_pending,
	input wire logic wdt_timeout,
	// Chip controls
	output idle_power_pkg::power_ctrl_s ctrl
);

	typedef struct packed {
		idle_power_pkg::power_state_e state;
		logic [2:0] pwm_off;
		logic timer_stop_in_idle;
		logic [1:0] cfg;
		logic irq_held;
		logic wdt_wake;
		logic [15:0] rdata;
		idle_power_pkg::power_ctrl_s ctrl;
	} state_s;

	state_s st_q;
	state_s st_d;
	logic resume_start;
	logic resume_done;

	// Read mux for the register port
	function automatic logic [15:0] read_reg(input logic [3:0] a, input state_s s);
		logic [15:0] v;
		v = 16'h0000;
		case (a)
			`OFS_PERIPHERAL_DISABLE_6: v[`BIT_PWM_GEN3_OFF:`BIT_PWM_GEN1_OFF] = s.pwm_off;
			`OFS_TIMER1_CONTROL: v[`BIT_TIMER_STOP_IN_IDLE] = s.timer_stop_in_idle;
			`OFS_POWER_CONFIG: v[1:0] = s.cfg;
			`OFS_POWER_STATUS: v[2:0] = s.state;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction : read_reg

	resume_timer u_resume (
		.core_clk(core_clk),
		.rst(rst),
		.start(resume_start),
		.done(resume_done)
	);

	// Next state, registers and control outputs
	always_comb begin
		logic in_idle;
		logic wake;
		in_idle = 1'b0;
		wake = 1'b0;
		st_d = st_q;
		resume_start = 1'b0;
		st_d.rdata = 16'h0000;
		st_d.ctrl.wdt_clear = 1'b0;
		// Register writes
		if (req.wr) begin
			case (req.addr)
				`OFS_PERIPHERAL_DISABLE_6:
					st_d.pwm_off = req.wdata[`BIT_PWM_GEN3_OFF:`BIT_PWM_GEN1_OFF];
				`OFS_TIMER1_CONTROL: st_d.timer_stop_in_idle = req.wdata[`BIT_TIMER_STOP_IN_IDLE];
				`OFS_POWER_CONFIG: st_d.cfg = req.wdata[1:0];
				default: st_d.cfg = st_q.cfg;
			endcase
		end
		if (req.rd) begin
			st_d.rdata = read_reg(req.addr, st_q);
		end
		wake = irq_enabled_pending | wdt_timeout;
		case (st_q.state)
			idle_power_pkg::ST_RUN: begin
				if (power_save_instruction) begin
					st_d.state = idle_power_pkg::ST_ENTER;
					st_d.ctrl.core_run = 1'b0;
					st_d.ctrl.core_clk_en = 1'b0;
					st_d.ctrl.wdt_clear = 1'b1;
					st_d.irq_held = 1'b0;
					st_d.wdt_wake = 1'b0;
				end
			end
			idle_power_pkg::ST_ENTER: begin
				// Hold off a coincident interrupt until entry is done
				st_d.irq_held = st_q.irq_held | irq_enabled_pending;
				st_d.wdt_wake = st_q.wdt_wake | wdt_timeout;
				st_d.state = idle_power_pkg::ST_IDLE;
			end
			idle_power_pkg::ST_IDLE: begin
				in_idle = 1'b1;
				if (wake | st_q.irq_held | st_q.wdt_wake) begin
					st_d.state = idle_power_pkg::ST_RESUME;
					st_d.ctrl.core_clk_en = 1'b1;
					st_d.ctrl.resume_at_isr = irq_enabled_pending | st_q.irq_held;
					resume_start = 1'b1;
				end
			end
			idle_power_pkg::ST_RESUME: begin
				if (resume_done) begin
					st_d.state = idle_power_pkg::ST_RUN;
					st_d.ctrl.core_run = 1'b1;
				end
			end
			default: st_d.state = idle_power_pkg::ST_RUN;
		endcase
		if (st_q.state == idle_power_pkg::ST_ENTER) begin
			in_idle = 1'b1;
		end
		// Peripheral clocks: system clock runs, each gated by its own controls
		st_d.ctrl.pwm_clk_en = ~st_d.pwm_off;
		st_d.ctrl.timer1_clk_en = ~((st_d.state != idle_power_pkg::ST_RUN)
			& (st_d.state != idle_power_pkg::ST_RESUME) & st_d.timer_stop_in_idle);
		st_d.ctrl.low_power_rc_oscillator_on = st_d.cfg[`BIT_CFG_WDT_EN] | st_d.cfg[`BIT_CFG_FAIL_SAFE_CLOCK_MONITOR_EN];
		if (in_idle & ~st_d.ctrl.low_power_rc_oscillator_on) begin
			st_d.ctrl.low_power_rc_oscillator_on = 1'b0;
		end
	end

	// State register; any reset also ends Idle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_q.state <= idle_power_pkg::ST_RUN;
			st_q.pwm_off <= `RST_PERIPHERAL_DISABLE_6;
			st_q.timer_stop_in_idle <= 1'b0;
			st_q.cfg <= `RST_POWER_CONFIG;
			st_q.irq_held <= 1'b0;
			st_q.wdt_wake <= 1'b0;
			st_q.rdata <= 16'h0000;
			st_q.ctrl <= '{core_clk_en: 1'b1, core_run: 1'b1, wdt_clear: 1'b0, low_power_rc_oscillator_on: 1'b0,
				pwm_clk_en: 3'h7, timer1_clk_en: 1'b1, resume_at_isr: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata = st_q.rdata;
	assign ctrl = st_q.ctrl;

	// Power-save request stops the core and clears the watchdog next cycle
	a_entry_stops_core: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_RUN && power_save_instruction)
		|=> (!ctrl.core_run && !ctrl.core_clk_en))
		else $error("core not stopped on idle entry");

	a_entry_wdt_clear: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_RUN && power_save_instruction) |=> ctrl.wdt_clear)
		else $error("watchdog not cleared on idle entry");

	a_pwm_gating: assert property (@(posedge core_clk) disable iff (rst)
		(req.wr && req.addr == `OFS_PERIPHERAL_DISABLE_6)
		|=> ctrl.pwm_clk_en == ~$past(req.wdata[`BIT_PWM_GEN3_OFF:`BIT_PWM_GEN1_OFF]))
		else $error("pwm clock enable does not follow disable bits");

	a_low_power_rc_oscillator_kept: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_IDLE && st_q.cfg != 2'h0) |-> ctrl.low_power_rc_oscillator_on)
		else $error("rc oscillator dropped in idle");

	sequence s_wake_start;
		st_q.state == idle_power_pkg::ST_IDLE && (irq_enabled_pending || wdt_timeout);
	endsequence

	a_wake_resume: assert property (@(posedge core_clk) disable iff (rst)
		s_wake_start |=> ctrl.core_clk_en ##[2:4] ctrl.core_run)
		else $error("resume latency outside two to four cycles");

	a_held_irq_wakes: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_ENTER && irq_enabled_pending)
		|=> ##1 (st_q.state == idle_power_pkg::ST_RESUME && ctrl.resume_at_isr))
		else $error("coincident interrupt lost");

	a_unimpl_zero: assert property (@(posedge core_clk) disable iff (rst)
		($past(req.rd) && $past(req.addr) == `OFS_PERIPHERAL_DISABLE_6)
		|-> (rdata[15:11] == 5'h00 && rdata[7:0] == 8'h00))
		else $error("unimplemented bits read nonzero");

	a_timer_stop: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_IDLE && st_q.timer_stop_in_idle) |-> !ctrl.timer1_clk_en)
		else $error("timer1 runs in idle with stop bit set");

	// Further checks on reset, entry, resume and register side effects

	// Reset puts every control back to its running default
	a_reset_defaults: assert property (@(posedge core_clk)
		rst |=> (ctrl.core_run && ctrl.core_clk_en && !ctrl.wdt_clear && ctrl.pwm_clk_en == 3'h7
			&& ctrl.timer1_clk_en && !ctrl.resume_at_isr && !ctrl.low_power_rc_oscillator_on && rdata == 16'h0000))
		else $error("controls not at defaults after reset");

	// Watchdog clear is a single pulse, only in the entry cycle
	a_wdt_clear_pulse: assert property (@(posedge core_clk) disable iff (rst)
		ctrl.wdt_clear |-> (st_q.state == idle_power_pkg::ST_ENTER) ##1 !ctrl.wdt_clear)
		else $error("watchdog clear outside entry or longer than one cycle");

	// Entry walk: request in RUN, one stopped cycle in ENTER, then IDLE
	sequence s_entry_req;
		st_q.state == idle_power_pkg::ST_RUN && power_save_instruction;
	endsequence

	sequence s_entry_done;
		(st_q.state == idle_power_pkg::ST_ENTER && ctrl.wdt_clear) ##1
			(st_q.state == idle_power_pkg::ST_IDLE && !ctrl.wdt_clear);
	endsequence

	a_entry_walk: assert property (@(posedge core_clk) disable iff (rst)
		s_entry_req |=> s_entry_done)
		else $error("idle entry did not pass through one entry cycle");

	// Core stays stopped through entry and Idle
	a_core_stopped: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_ENTER || st_q.state == idle_power_pkg::ST_IDLE)
		|-> (!ctrl.core_run && !ctrl.core_clk_en))
		else $error("core clock or execution on while idle");

	// Without a wake event Idle holds
	a_idle_waits: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_IDLE && !irq_enabled_pending && !wdt_timeout
			&& !st_q.irq_held && !st_q.wdt_wake) |=> st_q.state == idle_power_pkg::ST_IDLE)
		else $error("idle left without a wake event");

	// Resume: clock on, execution still held
	a_resume_clock_on: assert property (@(posedge core_clk) disable iff (rst)
		st_q.state == idle_power_pkg::ST_RESUME |-> (ctrl.core_clk_en && !ctrl.core_run))
		else $error("resume state with wrong clock or run control");

	// Resume lasts the fixed latency, then RUN
	sequence s_resume_window;
		(st_q.state == idle_power_pkg::ST_RESUME)[*3] ##1 (st_q.state == idle_power_pkg::ST_RUN);
	endsequence

	a_resume_length: assert property (@(posedge core_clk) disable iff (rst)
		s_wake_start |=> s_resume_window)
		else $error("resume window not three cycles");

	// Running state always lets the core execute
	a_run_running: assert property (@(posedge core_clk) disable iff (rst)
		st_q.state == idle_power_pkg::ST_RUN |-> (ctrl.core_run && ctrl.core_clk_en))
		else $error("core held while in run state");

	// Wake by interrupt resumes at the service routine
	a_resume_isr: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_IDLE && irq_enabled_pending) |=> ctrl.resume_at_isr)
		else $error("interrupt wake does not resume at service routine");

	// Wake by watchdog alone resumes after the power-save instruction
	a_resume_insn: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_IDLE && !irq_enabled_pending && !st_q.irq_held
			&& (wdt_timeout || st_q.wdt_wake)) |=> !ctrl.resume_at_isr)
		else $error("watchdog wake marked as interrupt");

	// Watchdog time-out during entry still wakes once Idle is reached
	a_held_wdt_wakes: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_ENTER && wdt_timeout)
		|=> ##1 st_q.state == idle_power_pkg::ST_RESUME)
		else $error("coincident watchdog time-out lost");

	// Timer1 clock runs whenever the core runs or resumes
	a_timer_runs: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_RUN || st_q.state == idle_power_pkg::ST_RESUME)
		|-> ctrl.timer1_clk_en)
		else $error("timer1 clock stopped outside idle");

	// Stop bit already holds timer1 in the entry cycle
	a_timer_stop_entry: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_ENTER && st_q.timer_stop_in_idle) |-> !ctrl.timer1_clk_en)
		else $error("timer1 runs during entry with stop bit set");

	// Peripherals keep their clock in Idle unless disabled
	a_timer_idle_on: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == idle_power_pkg::ST_IDLE && !st_q.timer_stop_in_idle) |-> ctrl.timer1_clk_en)
		else $error("timer1 clock stopped in idle without stop bit");

	a_pwm_idle_kept: assert property (@(posedge core_clk) disable iff (rst)
		st_q.state == idle_power_pkg::ST_IDLE |-> ctrl.pwm_clk_en == ~st_q.pwm_off)
		else $error("pwm clock changed by idle entry");

	// Oscillator keep-on follows the written watchdog and monitor enables
	a_low_power_rc_oscillator_config: assert property (@(posedge core_clk) disable iff (rst)
		(req.wr && req.addr == `OFS_POWER_CONFIG)
		|=> ctrl.low_power_rc_oscillator_on == ($past(req.wdata[`BIT_CFG_WDT_EN]) || $past(req.wdata[`BIT_CFG_FAIL_SAFE_CLOCK_MONITOR_EN])))
		else $error("rc oscillator keep-on does not follow config");

	// Writes to status or unmapped indexes change nothing
	a_unmapped_write: assert property (@(posedge core_clk) disable iff (rst)
		(req.wr && req.addr >= `OFS_POWER_STATUS)
		|=> ($stable(st_q.cfg) && $stable(st_q.pwm_off) && $stable(st_q.timer_stop_in_idle)))
		else $error("write to unmapped index changed a register");

	// Read data stands one cycle only
	a_read_stands: assert property (@(posedge core_clk) disable iff (rst)
		!$past(req.rd) |-> rdata == 16'h0000)
		else $error("read data outside its cycle");

	// Status read shows only the state code
	a_status_bits: assert property (@(posedge core_clk) disable iff (rst)
		($past(req.rd) && $past(req.addr) == `OFS_POWER_STATUS) |-> rdata[15:3] == 13'h0000)
		else $error("status read shows bits above the state code");

endmodule : idle_power_ctrl
`default_nettype wire

// ### core/idle_power_regs.svh
// Constants for the idle-mode power gating block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef IDLE_POWER_REGS_SVH
`define IDLE_POWER_REGS_SVH

// Register offsets
`define OFS_PERIPHERAL_DISABLE_6 4'h0
`define OFS_TIMER1_CONTROL 4'h1
`define OFS_POWER_CONFIG 4'h2
`define OFS_POWER_STATUS 4'h3

// Field positions
`define BIT_PWM_GEN1_OFF 8
`define BIT_PWM_GEN3_OFF 10
`define BIT_TIMER_STOP_IN_IDLE 13
`define BIT_CFG_WDT_EN 0
`define BIT_CFG_FAIL_SAFE_CLOCK_MONITOR_EN 1

// Reset values
`define RST_PERIPHERAL_DISABLE_6 3'h0
`define RST_TIMER1_CONTROL 16'h0000
`define RST_POWER_CONFIG 2'h0

// Wake latency: clocks from core clock return to first fetch
`define RESUME_CYCLES 3'h3

`endif

// ### core/idle_power_pkg.sv
// Types shared by the idle-mode power gating design.
// Assumes the constants header sits beside it in core/.
package idle_power_pkg;

	// Power state of the core
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_ENTER = 3'b001,
		ST_IDLE = 3'b010,
		ST_RESUME = 3'b011
	} power_state_e;

	// Register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	// Clock and power controls driven to the rest of the chip
	typedef struct packed {
		logic core_clk_en;
		logic core_run;
		logic wdt_clear;
		logic low_power_rc_oscillator_on;
		logic [2:0] pwm_clk_en;
		logic timer1_clk_en;
		logic resume_at_isr;
	} power_ctrl_s;

endpackage : idle_power_pkg

// ### core/resume_timer.sv
// Counts the wake latency between core clock return and first instruction.
// Assumes a start pulse from the power state machine on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "idle_power_regs.svh"
module resume_timer (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic start,
	output logic done
);

	typedef struct packed {
		logic [2:0] cnt;
		logic busy;
		logic done;
	} tmr_s;

	tmr_s st_q;
	tmr_s st_d;

	// Load on start, count down, pulse done at zero; load is two short since done and the run flop each add a cycle
	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		if (start) begin
			st_d.cnt = `RESUME_CYCLES - 3'h2;
			st_d.busy = 1'b1;
		end else if (st_q.busy) begin
			if (st_q.cnt == 3'h0) begin
				st_d.busy = 1'b0;
				st_d.done = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt - 3'h1;
			end
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign done = st_q.done;

endmodule : resume_timer
`default_nettype wire

// ### sim/core_model.sv
// Processor core stand-in: issues power-save pulses and later wake events.
// Assumes the bench pulses go for one cycle while the core runs.
`timescale 1ns/1ps
`default_nettype none
module core_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Bench control
	input wire logic go,
	input wire logic use_irq,
	input wire logic [3:0] gap,
	// Core side
	input wire logic core_run,
	output logic pws,
	output logic irq,
	output logic wdt
);
	logic [3:0] cnt_q;
	logic wait_q;
	// Power save, then wake by interrupt level or watchdog pulse after gap cycles
	always_ff @(posedge core_clk) begin
		pws <= go && core_run;
		wdt <= 1'b0;
		if (rst) begin
			cnt_q <= 4'h0;
			wait_q <= 1'b0;
			irq <= 1'b0;
		end else if (go) begin
			cnt_q <= gap;
			wait_q <= 1'b1;
			irq <= use_irq && gap == 4'h0;
		end else if (wait_q && cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end else if (wait_q) begin
			wait_q <= 1'b0;
			irq <= use_irq;
			wdt <= !use_irq;
		end else if (core_run) begin
			irq <= 1'b0; // Service routine clears it
		end
	end
endmodule : core_model
`default_nettype wire

// ### sim/test_idle_mode_power_gating.sv
// Self-checking bench for the idle power controller.
// Assumes the design files and constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "idle_power_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_idle_mode_power_gating;
	logic core_clk, rst, go, use_irq, pws, irq, wdt, rd_q, run_q;
	logic [3:0] gap;
	logic [2:0] lat, pwm_exp;
	logic [15:0] rdata, d, exp_v;
	logic [15:0] exp_q[$];
	idle_power_pkg::reg_req_s req;
	idle_power_pkg::power_ctrl_s ctrl;
	int err_count = 0, comparisons = 0, cyc = 0, i, n;
	int seed = 32'hc241;
	idle_power_ctrl u_dut (.core_clk(core_clk), .rst(rst), .req(req), .rdata(rdata),
		.power_save_instruction(pws), .irq_enabled_pending(irq), .wdt_timeout(wdt), .ctrl(ctrl));
	core_model u_core (.core_clk(core_clk), .rst(rst), .go(go), .use_irq(use_irq), .gap(gap),
		.core_run(ctrl.core_run), .pws(pws), .irq(irq), .wdt(wdt));
	// Clock and cycle ceiling
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end
	task stop_test();
		if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	// Register bus cycles
	task wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge core_clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		req <= '0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge core_clk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		exp_q.push_back(e);
		@(posedge core_clk);
		req <= '0;
	endtask : rd
	// One Idle visit, woken by interrupt, watchdog or reset
	task idle(input logic ui, input logic [3:0] g, input logic t1, input logic by_rst);
		@(posedge core_clk);
		go <= 1'b1;
		use_irq <= ui;
		gap <= g;
		@(posedge core_clk);
		go <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK(ctrl.core_run, 1'b0)
		`CHK(ctrl.core_clk_en, 1'b0)
		`CHK(ctrl.wdt_clear, 1'b1)
		`CHK(ctrl.timer1_clk_en, t1)
		`CHK(ctrl.pwm_clk_en, pwm_exp)
		`CHK(ctrl.low_power_rc_oscillator_on, 1'b1)
		if (g != 4'h0) rd(`OFS_POWER_STATUS, 16'h0002);
		if (by_rst) begin
			@(posedge core_clk);
			rst <= 1'b1;
			@(posedge core_clk);
			rst <= 1'b0;
			@(posedge core_clk);
			#1;
			`CHK(ctrl.core_run, 1'b1)
		end else begin
			exp_q.push_back({15'h0000, ui});
			n = 0;
			while (ctrl.core_run !== 1'b1 && n < 60) begin
				@(posedge core_clk);
				#1;
				n++;
			end
			`CHK(n < 60, 1'b1)
		end
	endtask : idle
	// Result watcher: read data and wake point against queued notes
	always @(posedge core_clk) begin
		rd_q <= req.rd;
		run_q <= ctrl.core_run;
		lat <= !ctrl.core_clk_en ? 3'h0 : (ctrl.core_run ? lat : lat + 3'h1);
		if (rd_q) begin
			exp_v = exp_q.pop_front();
			`CHK(rdata, exp_v)
		end
		if (ctrl.core_run && !run_q && exp_q.size() > 0) begin
			exp_v = exp_q.pop_front();
			`CHK({15'h0000, ctrl.resume_at_isr}, exp_v)
			`CHK(lat, `RESUME_CYCLES)
		end
	end
	// Main sequence
	initial begin
		req = '0;
		rst = 1'b1;
		go = 1'b0;
		use_irq = 1'b0;
		gap = 4'h0;
		lat = 3'h0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK(ctrl.pwm_clk_en, 3'h7)
		`CHK(ctrl.core_run, 1'b1)
		rd(`OFS_PERIPHERAL_DISABLE_6, 16'h0000);
		for (i = 0; i < 4; i++) begin
			d = 16'($random(seed));
			wr(`OFS_PERIPHERAL_DISABLE_6, d);
			rd(`OFS_PERIPHERAL_DISABLE_6, d & 16'h0700);
			wr(`OFS_POWER_CONFIG, 16'(i));
			repeat (2) @(posedge core_clk);
			#1;
			pwm_exp = ~d[10:8];
			`CHK(ctrl.pwm_clk_en, pwm_exp)
			`CHK(ctrl.low_power_rc_oscillator_on, 1'(i[0] | i[1]))
		end
		wr(4'hF, 16'hFFFF);
		rd(4'hF, 16'h0000);
		wr(`OFS_TIMER1_CONTROL, 16'h2000);
		rd(`OFS_TIMER1_CONTROL, 16'h2000);
		idle(1'b1, 4'h6, 1'b0, 1'b0);
		idle(1'b1, 4'h0, 1'b0, 1'b0);
		wr(`OFS_TIMER1_CONTROL, 16'h0000);
		idle(1'b0, 4'h6, 1'b1, 1'b0);
		idle(1'b0, 4'h0, 1'b1, 1'b0);
		idle(1'b0, 4'hF, 1'b1, 1'b1);
		`CHK(ctrl.pwm_clk_en, 3'h7)
		`CHK(ctrl.low_power_rc_oscillator_on, 1'b0)
		rd(`OFS_PERIPHERAL_DISABLE_6, 16'h0000);
		repeat (4) @(posedge core_clk);
		stop_test();
	end
endmodule : test_idle_mode_power_gating
`default_nettype wire
